// ==== common/pce_pkg.sv ====
// Constants and types of the pin change edge detector.
// Assumes one 25 MHz core clock and a 16-bit AXI4-Lite byte address.
// What this block does
// R1 - Each pin has a rising edge detector, active only while its rise enable is set.
// R2 - Each pin has a falling edge detector, active only while its fall enable is set.
// R3 - With both enable bits set, a pin catches edges in both directions.
// R4 - An enabled edge sets the pin's flag; interrupt only when module enable is set, or from the sticky wake bit when its own enable is set.
// R5 - Any pin or set of pins across ports may feed the interrupt.
// R6 - With module enable clear, edges still set flags but raise no interrupt, unless caught in sleep with the wake bit enable set.
// R7 - Read-only summary request is the OR of all flags, held until all clear.
// R8 - Writing zero clears a flag; writing one leaves it unchanged.
// R9 - An edge coinciding with a clearing write leaves its flag set.
// R10 - Software should clear flags by masking only bits already seen set.
// R11 - With module enable set, a detected change wakes the device from sleep.
// R12 - An edge in sleep reaches the flag register on the same clock edge that wake is signalled.
// R13 - Reset pin enable or low voltage program enable disables detection on the reset pin.
// R14 - Edges found by comparing each pin level with its previous sample.
package pce_pkg;

	localparam int PCE_NPORT = 4;
	localparam int PCE_PW = 8;
	localparam int PCE_AW = 16;
	localparam int PCE_IW = 14;

	// Register indices; byte address is four times the index
	localparam logic [PCE_IW-1:0] PCE_IDX_A_RISE = 14'h1E91;
	localparam logic [PCE_IW-1:0] PCE_IDX_A_FALL = 14'h1E92;
	localparam logic [PCE_IW-1:0] PCE_IDX_A_FLAG = 14'h1E93;
	localparam logic [PCE_IW-1:0] PCE_IDX_B_RISE = 14'h1E9B;
	localparam logic [PCE_IW-1:0] PCE_IDX_B_FALL = 14'h1E9C;
	localparam logic [PCE_IW-1:0] PCE_IDX_B_FLAG = 14'h1E9D;
	localparam logic [PCE_IW-1:0] PCE_IDX_C_RISE = 14'h1EA5;
	localparam logic [PCE_IW-1:0] PCE_IDX_C_FALL = 14'h1EA6;
	localparam logic [PCE_IW-1:0] PCE_IDX_C_FLAG = 14'h1EA7;
	localparam logic [PCE_IW-1:0] PCE_IDX_E_RISE = 14'h1EB9;
	localparam logic [PCE_IW-1:0] PCE_IDX_E_FALL = 14'h1EBA;
	localparam logic [PCE_IW-1:0] PCE_IDX_E_FLAG = 14'h1EBB;
	localparam logic [PCE_IW-1:0] PCE_IDX_CONFIG = 14'h1EC0;
	localparam logic [PCE_IW-1:0] PCE_IDX_STATUS = 14'h1EC1;
	localparam logic [PCE_IW-1:0] PCE_IDX_CLEAR = 14'h1EC2;
	localparam logic [PCE_IW-1:0] PCE_IDX_IRQEN = 14'h1EC3;

	// Port order everywhere: 0 = A, 1 = B, 2 = C, 3 = E
	localparam logic [PCE_IW-1:0] PCE_IDX_RISE [PCE_NPORT] = '{PCE_IDX_A_RISE, PCE_IDX_B_RISE,
		PCE_IDX_C_RISE, PCE_IDX_E_RISE};
	localparam logic [PCE_IW-1:0] PCE_IDX_FALL [PCE_NPORT] = '{PCE_IDX_A_FALL, PCE_IDX_B_FALL,
		PCE_IDX_C_FALL, PCE_IDX_E_FALL};
	localparam logic [PCE_IW-1:0] PCE_IDX_FLAG [PCE_NPORT] = '{PCE_IDX_A_FLAG, PCE_IDX_B_FLAG,
		PCE_IDX_C_FLAG, PCE_IDX_E_FLAG};
	// Pins able to detect change; other bits read zero
	localparam logic [PCE_PW-1:0] PCE_PIN_MASK [PCE_NPORT] = '{8'hFF, 8'hFF, 8'hFF, 8'h08};

	// External reset pin shares port E bit 3
	localparam int PCE_RST_PORT = 3;
	localparam logic [PCE_PW-1:0] PCE_RST_PIN_BIT = 8'h08;

	localparam logic [PCE_PW-1:0] PCE_ENABLE_RST = 8'h00;
	localparam logic [PCE_PW-1:0] PCE_FLAGS_RST = 8'h00;
	localparam int PCE_ST_W = 2;
	localparam int PCE_ST_SUMMARY = 0;
	localparam int PCE_ST_WAKE = 1;
	localparam logic [PCE_ST_W-1:0] PCE_IRQEN_RST = 2'h0;
	localparam logic [PCE_ST_W-1:0] PCE_STATUS_RST = 2'h0;
	localparam logic [1:0] PCE_CFG_RST = 2'h0;
	localparam logic [1:0] PCE_RESP_OKAY = 2'h0;
	localparam logic [1:0] PCE_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		PCE_SEL_NONE = 3'h0,
		PCE_SEL_RISE = 3'h1,
		PCE_SEL_FALL = 3'h2,
		PCE_SEL_FLAG = 3'h3,
		PCE_SEL_CFG = 3'h4,
		PCE_SEL_STAT = 3'h5,
		PCE_SEL_CLR = 3'h6,
		PCE_SEL_IEN = 3'h7
	} pce_sel_t;

	typedef struct packed {
		pce_sel_t sel;
		logic [1:0] port;
	} pce_dec_t;

	typedef struct packed {
		logic low_voltage_program_enable;
		logic ext_reset_pin_enable;
	} pce_cfg_t;

endpackage : pce_pkg

// ==== src/pce_pin_change_detect.sv ====
// Pin change edge detector with AXI4-Lite register slave.
// Assumes pin inputs already synchronous to core_clk and a sleep level from the core.
`timescale 1ns/1ps
module pce_pin_change_detect import pce_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [PCE_AW-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [PCE_AW-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] port_a_pins,
	input wire logic [7:0] port_b_pins,
	input wire logic [7:0] port_c_pins,
	input wire logic [3:0] port_e_pins,
	input wire logic sleep_mode,
	output logic irq,
	output logic change_irq_request,
	output logic wake_req
);

	function automatic pce_dec_t pce_decode(input logic [PCE_AW-1:0] addr);
		pce_dec_t d;
		logic [PCE_IW-1:0] idx;
		d.sel = PCE_SEL_NONE;
		d.port = 2'h0;
		idx = addr[PCE_AW-1:2];
		for (int p = 0; p < PCE_NPORT; p++) begin
			if (idx == PCE_IDX_RISE[p]) begin
				d.sel = PCE_SEL_RISE;
				d.port = 2'(p);
			end
			if (idx == PCE_IDX_FALL[p]) begin
				d.sel = PCE_SEL_FALL;
				d.port = 2'(p);
			end
			if (idx == PCE_IDX_FLAG[p]) begin
				d.sel = PCE_SEL_FLAG;
				d.port = 2'(p);
			end
		end
		if (idx == PCE_IDX_CONFIG) begin
			d.sel = PCE_SEL_CFG;
		end
		if (idx == PCE_IDX_STATUS) begin
			d.sel = PCE_SEL_STAT;
		end
		if (idx == PCE_IDX_CLEAR) begin
			d.sel = PCE_SEL_CLR;
		end
		if (idx == PCE_IDX_IRQEN) begin
			d.sel = PCE_SEL_IEN;
		end
		return d;
	endfunction : pce_decode

	// Bus side state
	logic aw_held_reg;
	logic w_held_reg;
	logic [PCE_AW-1:0] aw_addr_reg;
	logic [PCE_PW-1:0] w_byte_reg;
	logic w_lane0_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// Detector state
	logic [PCE_PW-1:0] rise_reg [PCE_NPORT];
	logic [PCE_PW-1:0] fall_reg [PCE_NPORT];
	logic [PCE_PW-1:0] flags_reg [PCE_NPORT];
	logic [PCE_PW-1:0] prev_reg [PCE_NPORT];
	logic primed_reg;
	pce_cfg_t cfg_reg;
	logic [PCE_ST_W-1:0] ien_reg;
	logic wake_seen_reg;
	logic summary_reg;
	logic irq_reg;
	logic wake_reg;

	// Write channel handshakes
	wire aw_fire = s_axi_awvalid & awready_reg;
	wire w_fire = s_axi_wvalid & wready_reg;
	wire wr_do = aw_held_reg & w_held_reg & ~bvalid_reg;
	wire aw_held_next = (aw_held_reg & ~wr_do) | aw_fire;
	wire w_held_next = (w_held_reg & ~wr_do) | w_fire;
	wire bvalid_next = wr_do | (bvalid_reg & ~s_axi_bready);
	wire pce_dec_t wr_dec = pce_decode(aw_addr_reg);
	wire wr_hit = (wr_dec.sel != PCE_SEL_NONE);
	// Only lane 0 carries register data; upper lanes are ignored
	wire wr_apply = wr_do & w_lane0_reg;

	// Read channel handshakes
	wire ar_fire = s_axi_arvalid & arready_reg;
	wire rvalid_next = ar_fire | (rvalid_reg & ~s_axi_rready);
	wire pce_dec_t rd_dec = pce_decode(s_axi_araddr);
	wire rd_hit = (rd_dec.sel != PCE_SEL_NONE);

	// Pin vector and reset pin gating
	wire [PCE_PW-1:0] pin_vec [PCE_NPORT];
	assign pin_vec[0] = port_a_pins;
	assign pin_vec[1] = port_b_pins;
	assign pin_vec[2] = port_c_pins;
	assign pin_vec[3] = {4'h0, port_e_pins};
	// R13 reset pin excluded
	wire rst_pin_off = cfg_reg.ext_reset_pin_enable | cfg_reg.low_voltage_program_enable;

	wire [PCE_PW-1:0] rise_next [PCE_NPORT];
	wire [PCE_PW-1:0] fall_next [PCE_NPORT];
	wire [PCE_PW-1:0] flags_next [PCE_NPORT];
	wire [PCE_PW-1:0] new_edges [PCE_NPORT];
	wire [PCE_NPORT-1:0] port_any_edge;
	wire [PCE_NPORT-1:0] port_any_flag;

	genvar gp;
	generate
		for (gp = 0; gp < PCE_NPORT; gp++) begin : g_port
			wire [PCE_PW-1:0] usable;
			wire [PCE_PW-1:0] rise_hit;
			wire [PCE_PW-1:0] fall_hit;
			wire [PCE_PW-1:0] flag_keep;
			wire wr_this = wr_apply & (wr_dec.port == 2'(gp));
			wire flag_wr = wr_this & (wr_dec.sel == PCE_SEL_FLAG);
			wire rise_wr = wr_this & (wr_dec.sel == PCE_SEL_RISE);
			wire fall_wr = wr_this & (wr_dec.sel == PCE_SEL_FALL);
			// R13 reset pin masked
			assign usable = PCE_PIN_MASK[gp] & ~((gp == PCE_RST_PORT && rst_pin_off) ? PCE_RST_PIN_BIT : 8'h00);
			// R14 compare with previous sample
			// R1 rising gated by enable
			assign rise_hit = pin_vec[gp] & ~prev_reg[gp] & rise_reg[gp] & usable & {PCE_PW{primed_reg}};
			// R2 falling gated by enable
			assign fall_hit = ~pin_vec[gp] & prev_reg[gp] & fall_reg[gp] & usable & {PCE_PW{primed_reg}};
			// R3 both directions together
			assign new_edges[gp] = rise_hit | fall_hit;
			// R8 zero clears, one keeps
			assign flag_keep = flag_wr ? w_byte_reg : 8'hFF;
			// R9 set wins over clear
			assign flags_next[gp] = ((flags_reg[gp] & flag_keep) | new_edges[gp]) & PCE_PIN_MASK[gp];
			assign rise_next[gp] = rise_wr ? (w_byte_reg & PCE_PIN_MASK[gp])
				: rise_reg[gp];
			assign fall_next[gp] = fall_wr ? (w_byte_reg & PCE_PIN_MASK[gp])
				: fall_reg[gp];
			assign port_any_edge[gp] = |new_edges[gp];
			// R5 every port feeds summary
			assign port_any_flag[gp] = |flags_next[gp];

			// One flop bank per port
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					rise_reg[gp] <= PCE_ENABLE_RST;
					fall_reg[gp] <= PCE_ENABLE_RST;
					flags_reg[gp] <= PCE_FLAGS_RST;
					prev_reg[gp] <= 8'h00;
				end else begin
					rise_reg[gp] <= rise_next[gp];
					fall_reg[gp] <= fall_next[gp];
					flags_reg[gp] <= flags_next[gp];
					prev_reg[gp] <= pin_vec[gp];
				end
			end
		end
	endgenerate

	// R7 OR of every flag
	wire summary_next = |port_any_flag;
	wire any_edge = |port_any_edge;
	wire ien_write = wr_apply & (wr_dec.sel == PCE_SEL_IEN);
	wire clr_write = wr_apply & (wr_dec.sel == PCE_SEL_CLR);
	wire cfg_write = wr_apply & (wr_dec.sel == PCE_SEL_CFG);
	wire [PCE_ST_W-1:0] ien_next = ien_write ? w_byte_reg[PCE_ST_W-1:0] : ien_reg;
	wire change_irq_enable = ien_next[PCE_ST_SUMMARY];
	// Edge caught in sleep sets the sticky bit; set beats clear
	wire wake_seen_next = (sleep_mode & any_edge) | (wake_seen_reg & ~(clr_write & w_byte_reg[PCE_ST_WAKE]));
	wire [PCE_ST_W-1:0] status_next = {wake_seen_next, summary_next};
	// R4 summary interrupt needs module enable; the sticky wake bit needs only its own enable
	// R6 flags kept, no summary interrupt; an edge in sleep still interrupts if the wake bit is enabled
	wire irq_next = |(status_next & ien_next);
	// R11 wake gated by module enable
	// R12 flag and wake load on the same edge
	wire wake_next = sleep_mode & change_irq_enable & summary_next;

	// Read data selection
	wire [PCE_PW-1:0] rd_rise_byte = rise_reg[rd_dec.port];
	wire [PCE_PW-1:0] rd_fall_byte = fall_reg[rd_dec.port];
	wire [PCE_PW-1:0] rd_flag_byte = flags_reg[rd_dec.port];
	wire [PCE_PW-1:0] rd_cfg_byte = {6'h00, cfg_reg};
	wire [PCE_PW-1:0] rd_stat_byte = {6'h00, wake_seen_reg, summary_reg};
	wire [PCE_PW-1:0] rd_ien_byte = {6'h00, ien_reg};
	wire [PCE_PW-1:0] rd_byte =
		(rd_dec.sel == PCE_SEL_RISE) ? rd_rise_byte :
		(rd_dec.sel == PCE_SEL_FALL) ? rd_fall_byte :
		(rd_dec.sel == PCE_SEL_FLAG) ? rd_flag_byte :
		(rd_dec.sel == PCE_SEL_CFG) ? rd_cfg_byte :
		(rd_dec.sel == PCE_SEL_STAT) ? rd_stat_byte :
		(rd_dec.sel == PCE_SEL_IEN) ? rd_ien_byte : 8'h00;

	// Ready drops while a beat is held, so no second beat lands before the write
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			aw_held_reg <= 1'b0;
			awready_reg <= 1'b0;
		end else begin
			aw_held_reg <= aw_held_next;
			awready_reg <= ~aw_held_next;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			w_held_reg <= 1'b0;
			wready_reg <= 1'b0;
		end else begin
			w_held_reg <= w_held_next;
			wready_reg <= ~w_held_next;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			aw_addr_reg <= 16'h0000;
		end else if (aw_fire) begin
			aw_addr_reg <= s_axi_awaddr;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			w_byte_reg <= 8'h00;
			w_lane0_reg <= 1'b0;
		end else if (w_fire) begin
			w_byte_reg <= s_axi_wdata[PCE_PW-1:0];
			w_lane0_reg <= s_axi_wstrb[0];
		end
	end

	// Response waits for both beats; unmapped words answer with an error
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= PCE_RESP_OKAY;
		end else begin
			bvalid_reg <= bvalid_next;
			if (wr_do) begin
				bresp_reg <= wr_hit ? PCE_RESP_OKAY : PCE_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Read data is captured on acceptance and held until taken
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= PCE_RESP_OKAY;
		end else if (ar_fire) begin
			rdata_reg <= {24'h00_0000, rd_byte};
			rresp_reg <= rd_hit ? PCE_RESP_OKAY : PCE_RESP_SLVERR;
		end
	end

	// Priming stops the first sample after reset counting as an edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			primed_reg <= 1'b0;
		end else begin
			primed_reg <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_reg <= PCE_CFG_RST;
		end else if (cfg_write) begin
			cfg_reg <= w_byte_reg[1:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ien_reg <= PCE_IRQEN_RST;
		end else begin
			ien_reg <= ien_next;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wake_seen_reg <= 1'b0;
			summary_reg <= 1'b0;
		end else begin
			wake_seen_reg <= wake_seen_next;
			summary_reg <= summary_next;
		end
	end

	// Request lines leave straight from flops, loaded on the same edge as the flags
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
			wake_reg <= wake_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign irq = irq_reg;
	assign change_irq_request = summary_reg;
	assign wake_req = wake_reg;

endmodule : pce_pin_change_detect

// ==== testbench/pce_pin_model.sv ====
// Pin drive model: external levels on the change-capable ports.
// Assumes the bench sets target levels and a lag in core_clk cycles.
`timescale 1ns/1ps
module pce_pin_model (
	input wire logic core_clk,
	input wire logic [27:0] want,
	input wire logic [3:0] lag,
	output logic [27:0] pins
);
	logic [3:0] wait_reg = 4'h0;
	initial pins = 28'h0;
	// Levels move just after an edge, so the sampling edge never races them
	always @(posedge core_clk) begin
		if (want == pins) begin
			wait_reg <= 4'h0;
		end else if (wait_reg >= lag) begin
			pins <= want;
			wait_reg <= 4'h0;
		end else begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule : pce_pin_model

// ==== testbench/pce_checker.sv ====
// Checker: bus answers, flag summary, pin cause and wake relations.
// Assumes binding to the detector top; sees its ports only.
`timescale 1ns/1ps
module pce_checker import pce_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [7:0] port_a_pins,
	input wire logic [7:0] port_b_pins,
	input wire logic [7:0] port_c_pins,
	input wire logic [3:0] port_e_pins,
	input wire logic sleep_mode,
	input wire logic change_irq_request,
	input wire logic wake_req
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	wire [27:0] pins_w = {port_e_pins, port_c_pins, port_b_pins, port_a_pins};
	sequence wr_taken_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_done_s;
		##1 s_axi_bvalid;
	endsequence
	write_resp_a: assert property (wr_taken_s |=> wr_done_s)
		else $error("write answer late");
	read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	edge_cause_a: assert property ($rose(change_irq_request) |-> $past(pins_w) != $past(pins_w, 2))
		else $error("request without pin change");
	flag_clear_a: assert property ($fell(change_irq_request) |-> s_axi_bvalid)
		else $error("request fell without write");
	wake_sleep_a: assert property (wake_req |-> $past(sleep_mode))
		else $error("wake outside sleep");
	wake_flag_a: assert property (wake_req |-> change_irq_request)
		else $error("wake before flag");
endmodule : pce_checker

// ==== testbench/pce_pin_change_detect_tb_top.sv ====
// Bench top: random pin traffic and register access over AXI4-Lite.
// Assumes package, pin model and checker compiled before it.
`timescale 1ns/1ps
module pce_pin_change_detect_tb_top import pce_pkg::*;;
	logic core_clk = 1'h0, rst = 1'h1, sleep_mode = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [PCE_AW-1:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF, lag = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, cfg = 2'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, change_irq_request, wake_req, ie;
	logic [27:0] want = 28'h0, pins;
	logic [7:0] m, rise [4] = '{default: 8'h00}, fall [4] = '{default: 8'h00}, ef [4] = '{default: 8'h00};
	wire [7:0] port_a_pins = pins[7:0];
	wire [7:0] port_b_pins = pins[15:8];
	wire [7:0] port_c_pins = pins[23:16];
	wire [3:0] port_e_pins = pins[27:24];
	int n_mismatch = 0, n_compared = 0, seed = 96326;
	pce_pin_change_detect u_pce_pin_change_detect (.*);
	pce_pin_model u_pce_pin_model (.core_clk(core_clk), .want(want), .lag(lag), .pins(pins));
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [13:0] i, input logic [7:0] v, input logic [1:0] er = PCE_RESP_OKAY);
		logic a, w;
		a = 1'h1;
		w = 1'h1;
		@(posedge core_clk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (a || w) begin
			@(posedge core_clk);
			if (s_axi_awready) a = 1'h0;
			if (s_axi_wready) w = 1'h0;
			s_axi_awvalid <= a;
			s_axi_wvalid <= w;
		end
		// Late bready lets the response stand a cycle unanswered
		while (!s_axi_bvalid) @(posedge core_clk);
		s_axi_bready <= 1'h1;
		@(posedge core_clk);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		s_axi_bready <= 1'h0;
	endtask : wr
	task automatic rd(input logic [13:0] i);
		@(posedge core_clk);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'h1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		while (!s_axi_rvalid) @(posedge core_clk);
		s_axi_rready <= 1'h1;
		@(posedge core_clk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : rd
	task automatic rchk(input logic [13:0] i, input logic [7:0] e);
		rd(i);
		chk($sformatf("reg %h", i), {24'h0, e}, d);
		chk("rresp", {30'h0, PCE_RESP_OKAY}, {30'h0, r});
	endtask : rchk
	function automatic logic [7:0] prt(input logic [27:0] v, input int p);
		return (p == 3) ? {4'h0, v[27:24]} : v[p*8+:8];
	endfunction : prt
	function automatic logic [7:0] edges(input int p, input logic [27:0] o, input logic [27:0] n);
		logic [7:0] k;
		k = PCE_PIN_MASK[p] & ((p == PCE_RST_PORT && cfg != 2'h0) ? ~PCE_RST_PIN_BIT : 8'hFF);
		return k & ((rise[p] & ~prt(o, p) & prt(n, p)) | (fall[p] & prt(o, p) & ~prt(n, p)));
	endfunction : edges
	function automatic logic any_f();
		return |{ef[0], ef[1], ef[2], ef[3]};
	endfunction : any_f
	task automatic setup(input int p, input logic [7:0] rr, input logic [7:0] ff);
		rise[p] = rr;
		fall[p] = ff;
		wr(PCE_IDX_RISE[p], rr);
		wr(PCE_IDX_FALL[p], ff);
	endtask : setup
	task automatic step(input logic [27:0] nw);
		@(posedge core_clk);
		for (int p = 0; p < 4; p++) ef[p] |= edges(p, want, nw);
		want <= nw;
		repeat (4) @(posedge core_clk);
	endtask : step
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'h0;
		for (int p = 0; p < 4; p++) begin
			rchk(PCE_IDX_RISE[p], 8'h00);
			rchk(PCE_IDX_FALL[p], 8'h00);
			rchk(PCE_IDX_FLAG[p], 8'h00);
		end
		rd(14'h0100);
		chk("unmapped rdata", 32'h0, d);
		chk("unmapped rresp", {30'h0, PCE_RESP_SLVERR}, {30'h0, r});
		wr(14'h0100, 8'hFF, PCE_RESP_SLVERR);
		for (int k = 0; k < 24; k++) begin
			ie = 1'($random(seed));
			wr(PCE_IDX_IRQEN, {7'h0, ie});
			for (int p = 0; p < 4; p++) setup(p, 8'($random(seed)), 8'($random(seed)));
			step(28'($random(seed)));
			chk("summary", {31'h0, any_f()}, {31'h0, change_irq_request});
			chk("irq", {31'h0, ie & any_f()}, {31'h0, irq});
			for (int p = 0; p < 4; p++) begin
				rchk(PCE_IDX_FLAG[p], ef[p]);
				rchk(PCE_IDX_RISE[p], rise[p] & PCE_PIN_MASK[p]);
				m = 8'($random(seed));
				wr(PCE_IDX_FLAG[p], ~(ef[p] & m));
				ef[p] &= ~m;
			end
		end
		setup(0, 8'hFF, 8'hFF);
		lag <= 4'h1;
		want <= want ^ 28'h1;
		wr(PCE_IDX_A_FLAG, 8'h00);
		ef[0] = 8'h01;
		rchk(PCE_IDX_A_FLAG, 8'h01);
		lag <= 4'h0;
		for (int s = 0; s < 2; s++) begin
			wr(PCE_IDX_IRQEN, {6'h0, s[0], s[0]});
			sleep_mode <= 1'h1;
			step(want ^ 28'h2);
			chk("wake", {31'h0, s[0]}, {31'h0, wake_req});
			sleep_mode <= 1'h0;
			chk("irq", {31'h0, s[0]}, {31'h0, irq});
			rchk(PCE_IDX_A_FLAG, ef[0]);
			if (s == 1) rchk(PCE_IDX_STATUS, {6'h0, 1'h1, any_f()});
			wr(PCE_IDX_CLEAR, 8'h02);
		end
		wr(PCE_IDX_STATUS, 8'hFF);
		rchk(PCE_IDX_STATUS, {7'h0, any_f()});
		rchk(PCE_IDX_CLEAR, 8'h00);
		setup(3, 8'h08, 8'h08);
		wr(PCE_IDX_E_FLAG, 8'h00);
		ef[3] = 8'h00;
		for (int c = 3; c >= 0; c--) begin
			cfg = c[1:0];
			wr(PCE_IDX_CONFIG, {6'h0, cfg});
			step(want ^ 28'h8000000);
			rchk(PCE_IDX_E_FLAG, ef[3]);
		end
		s_axi_wstrb <= 4'h0;
		wr(PCE_IDX_A_RISE, 8'h00);
		s_axi_wstrb <= 4'hF;
		rchk(PCE_IDX_A_RISE, 8'hFF);
		finish_test();
	end
	// Generous bound: the sequence needs roughly 2700 cycles
	initial begin
		#(40 * 20000);
		n_mismatch++;
		finish_test();
	end
endmodule : pce_pin_change_detect_tb_top
bind pce_pin_change_detect pce_checker u_pce_checker (.*);
